// ### bench/tcvf_dev_model.sv
// tcvf_dev_model: behavioural codec on the far end of the bus
// assumes linear layout; the tb resolves the downstream open-drain line with a pull-up
`timescale 1ns/100ps
module tcvf_dev_model (
  // bus pins
  input  wire logic       bus_data_clock,
  input  wire logic       frame_sync,
  input  wire logic       slot_group_select,
  input  wire logic       dd,
  output logic            du,
  // test control and capture
  input  wire logic [1:0] pair,
  input  wire logic       tx_go,
  output logic [7:0]      rx_mem [0:31],
  output int              rx_cnt,
  output logic [5:0]      sub_in
);
  int         bn = 0;                     // bit of frame, set mid bit
  int         nb;                         // bit about to start
  logic [7:0] sh, ub, mon_in, mon_prev;   // shifter, out byte, monitor bytes
  logic       mr_out = 1, mx_out = 1;     // own flags, active low
  logic       mr_in = 1, mx_in = 1;       // host flags
  logic       prev_ok = 0, sent = 0;      // last look valid, message done
  initial begin
    rx_cnt = 0;
    du = 1;
  end
  // byte k of the upstream frame
  function automatic logic [7:0] up_byte(int k);
    int s, q;
    s = k / 4;
    q = s % 4;
    if (s / 4 == int'(slot_group_select)) begin
      // control slot, bidir one as input
      case (k % 4)
        2: return (q == pair && !mx_out) ? 8'h5A : 8'hFF;
        3: return {q[1:0], 4'hA, q == pair ? {mr_out, mx_out} : 2'h3};
        default: return 8'hFF;
      endcase
    end
    // linear voice A then B, high byte first
    return (k % 2) ? 8'h50 + 8'(k % 4 / 2 + q * 2) : 8'hA0 + 8'(k % 4 / 2 + q * 2);
  endfunction
  // shift out msb first; a 1 is driven high, du has no pull-up
  always @(posedge bus_data_clock) begin
    nb = (bn + 1) % 256;
    ub = up_byte(nb / 8);
    du <= ub[7 - nb % 8];
  end
  // sync sampled mid bit to dodge the edge race
  always @(negedge bus_data_clock) begin
    bn = frame_sync ? 0 : (bn + 1) % 256;
    sh = {sh[6:0], dd};
    // sub-byte captured as the pin values it drives
    if (bn % 8 == 7 && bn / 32 % 4 == pair && bn / 128 == int'(slot_group_select)) begin
      if (bn % 32 == 23) mon_in = sh;
      if (bn % 32 == 31) {sub_in, mr_in, mx_in} = sh;
    end
    if (bn == 255) begin
      // last look, acknowledge; idle flag drops all
      if (mx_in) mr_out = 1;
      else if (prev_ok && mon_in == mon_prev && mr_out) begin
        rx_mem[rx_cnt] = mon_in;
        rx_cnt++;
        mr_out = 0;
      end
      prev_ok = !mx_in;
      mon_prev = mon_in;
      if (!mx_out && !mr_in) begin
        mx_out = 1;
        sent = 1;
      end else if (tx_go && !sent) mx_out = 0;
    end
  end
endmodule

// ### bench/tcvf_host_tb.sv
// tcvf_host_tb: self-checking bench, bus master against the codec model
// assumes the design's own assertions are compiled with it
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tcvf_host_tb;
  import tcvf_pkg::*;
  logic        sys_clk = 0, rstn = 0, grp = 0, valid = 0, jam = 0, go = 0;
  logic [7:0]  txd = 0, rx_data;
  logic        ready, rx_valid, end_of_message, abort, busy, fdone, bdc, fsync, crs, sgs;
  logic        dd_o, dd_oe, du;
  logic [7:0]  rx_mem [0:31];
  logic [5:0]  sub_in;
  int          rx_cnt, err_total = 0, samples_checked = 0, k, n;
  tcvf_sig_t   sig_down = {4{6'h2D}}, sig_up;
  tcvf_voice_t voice_down = '0, voice_up;
  wire         dd = (dd_oe | jam) ? 1'b0 : 1'b1;  // open drain, pull-up
  initial forever #50 sys_clk = ~sys_clk;
  tcvf_host i_tcvf_host (.sys_clk(sys_clk), .rstn(rstn), .cfg_slot_group(grp),
    .mon_pair(2'h1), .mon_tx_data(txd), .mon_tx_valid(valid), .mon_tx_ready(ready),
    .mon_tx_hold(1'b0), .mon_rx_data(rx_data), .mon_rx_valid(rx_valid), .mon_eom(end_of_message),
    .mon_abort(abort), .mon_busy(busy), .sig_down(sig_down), .sig_up(sig_up),
    .voice_down(voice_down), .voice_up(voice_up), .frame_done(fdone),
    .bus_data_clock(bdc), .frame_sync(fsync), .clock_rate_select(crs),
    .slot_group_select(sgs), .downstream_data_line_o(dd_o),
    .downstream_data_line_oe(dd_oe), .downstream_data_line_i(dd),
    .upstream_data_line(du));
  tcvf_dev_model i_tcvf_dev_model (.bus_data_clock(bdc), .frame_sync(fsync),
    .slot_group_select(sgs), .dd(dd), .du(du), .pair(2'h1), .tx_go(go),
    .rx_mem(rx_mem), .rx_cnt(rx_cnt), .sub_in(sub_in));
  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // wait for a design flag, bounded, then check it
  task automatic await(ref logic s, input int lim);
    for (k = 0; s !== 1'b1 && k < lim; k++) @(negedge sys_clk);
    `CHK(s, 1'b1)
  endtask
  // whole frames, ending on a falling edge
  task automatic frames(int f);
    repeat (f) @(posedge fdone);
    @(negedge sys_clk);
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    rstn = 1;
    for (int g = 0; g < 2; g++) begin
      grp = g[0];
      frames(3);
      for (int q = 0; q < 4; q++) `CHK(sig_up[q], {q[1:0], 4'hA})
      for (int c = 0; c < 8; c++) `CHK(voice_up[c], {8'hA0 + 8'(c), 8'h50 + 8'(c)})
      `CHK(sub_in, 6'h2D)
      `CHK(sgs, grp)
      `CHK(crs, 1'b0)
      `CHK(dd_o, 1'b0)
      $display("slot group test %0d done", g);
    end
    go = 1;
    await(rx_valid, 9000);
    `CHK(rx_data, 8'h5A)
    `CHK(busy, 1'b1)
    await(end_of_message, 9000);
    $display("device message test done");
    frames(1);
    `CHK(busy, 1'b0)
    repeat (10) @(negedge sys_clk);
    // fill the queue until it refuses
    for (n = 0; ready && n < 20; n++) begin
      txd = 8'h10 + 8'(n);
      valid = 1;
      @(negedge sys_clk);
    end
    valid = 0;
    `CHK(n >= 16, 1'b1)
    for (k = 0; rx_cnt < n && k < 95000; k++) @(negedge sys_clk);
    for (int i = 0; i < n; i++) `CHK(rx_mem[i], 8'h10 + 8'(i))
    await(end_of_message, 5000);
    `CHK(ready, 1'b1)
    $display("host message test done");
    txd = 8'hC3;
    valid = 1;
    @(negedge sys_clk);
    valid = 0;
    jam = 1;
    await(abort, 5000);
    jam = 0;
    $display("collision test done");
    results();
  end
  // hang guard
  initial begin
    #9600000;
    err_total++;
    results();
  end
endmodule

// ### common/tcvf_cfg.svh
// tcvf_cfg.svh: timing, framing and fifo constants of the gci bus master
// assumes a 10 MHz system clock and the linear frame layout on the device
// Operation
// RQ1: linear frame: eight slots, four bytes each
// RQ2: control slot: two spare, monitor, signaling octet
// RQ3: voice slot: 16-bit sample A, then B
// RQ4: select pin low: control slots 0-3
// RQ5: signaling octet every frame, msb first
// RQ6: upstream octet: inputs, bidir one, flags
// RQ7: bidir one reported only as input
// RQ8: downstream b7 picks channel, b6-b2 drive
// RQ9: bidir pins driven only when outputs
// RQ10: monitor byte carries register and ram commands
// RQ11: flags high two frames means idle
// RQ12: transmit flag low with first byte, hold
// RQ13: repeat byte every frame, check receive flag
// RQ14: acknowledge with receive flag low
// RQ15: hold back only while both flags active
// RQ16: accept byte after two equal frames
// RQ17: collision: flag phase and bitwise readback
// RQ18: abort clears device command stack
// RQ19: present next byte right after acknowledge
// RQ20: master silent while device transmits
// RQ21: bits framed by sync, bytes by handshake
// RQ22: bus clock single or double rate
// RQ23: send downstream, receive upstream, sync frames
// RQ24: format bit selects compressed or linear; this host has no format bit and handles linear only
// RQ25: flags back high, two idle frames end
`ifndef TCVF_CFG_SVH
`define TCVF_CFG_SVH
`define TCVF_SYS_KHZ 10000
`define TCVF_BIT_KHZ 2048
`define TCVF_BIT_CYC (`TCVF_SYS_KHZ / `TCVF_BIT_KHZ)
`define TCVF_LAST_BIT 8'hFF
`define TCVF_MON_BYTE 2'h2
`define TCVF_SIG_BYTE 2'h3
`define TCVF_FLAG_BIT 3'h0
`define TCVF_IDLE_FRAMES 2'h2
`define TCVF_IDLE_BYTE 8'hFF
`define TCVF_FIFO_DEPTH 16
`define TCVF_FIFO_WIDTH 8
`endif

// ### common/tcvf_pkg.sv
// tcvf_pkg: state and carrier types of the gci bus master
// assumes tcvf_cfg.svh is on the include path
`include "tcvf_cfg.svh"
package tcvf_pkg;
  // monitor transmitter states
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_SEND = 4'h2,
    TX_NEW  = 4'h4,
    TX_EOM  = 4'h8
  } tcvf_tx_e;
  // monitor receiver states
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_LOOK = 3'h2,
    RX_ACK  = 3'h4
  } tcvf_rx_e;
  // signaling octet as seen on either line
  typedef struct packed {
    logic [5:0] sub;
    logic       mr;
    logic       mx;
  } tcvf_ctl_s;
  typedef logic [3:0][5:0]  tcvf_sig_t;
  typedef logic [7:0][15:0] tcvf_voice_t;
endpackage

// ### logic/tcvf_fifo.sv
// tcvf_fifo: small synchronous fifo with valid and ready on both sides
// assumes one clock; the reader may stall, so the fifo really fills
`timescale 1ns/100ps
`include "tcvf_cfg.svh"
module tcvf_fifo #(
  parameter int W = `TCVF_FIFO_WIDTH,
  parameter int D = `TCVF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // filling side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // draining side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(D);

  logic [W-1:0] mem [D];          // storage words
  logic [AW-1:0] wr_reg;          // write pointer
  logic [AW-1:0] rd_reg;          // read pointer
  logic [AW:0]   cnt_reg;         // words held
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];

  // count follows push and pop together
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      // ready is registered so the source sees back-pressure from a flop
      in_ready <= (cnt_next != FULL);
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule

// ### logic/tcvf_host.sv
// tcvf_host: gci bus master for an eight channel codec in linear mode
// makes bus clock and frame sync itself; upstream and readback pins are
// synchronised; user side is plain ports on the system clock
`timescale 1ns/100ps
`include "tcvf_cfg.svh"
module tcvf_host
  import tcvf_pkg::*;
#(
  parameter int BIT_CYC = `TCVF_BIT_CYC,     // system cycles per bus bit
  parameter bit DOUBLE  = 1'b0,              // two bus clocks per bit
  parameter int FIFO_D  = `TCVF_FIFO_DEPTH   // monitor transmit queue
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // configuration
  input  wire logic        cfg_slot_group,
  // monitor transmit
  input  wire logic [1:0]  mon_pair,
  input  wire logic [7:0]  mon_tx_data,
  input  wire logic        mon_tx_valid,
  output logic             mon_tx_ready,
  input  wire logic        mon_tx_hold,
  // monitor receive and status
  output logic [7:0]       mon_rx_data,
  output logic             mon_rx_valid,
  output logic             mon_eom,
  output logic             mon_abort,
  output logic             mon_busy,
  // signaling and voice
  input  wire tcvf_sig_t   sig_down,
  output tcvf_sig_t        sig_up,
  input  wire tcvf_voice_t voice_down,
  output tcvf_voice_t      voice_up,
  output logic             frame_done,
  // bus pins
  output logic             bus_data_clock,
  output logic             frame_sync,
  output logic             clock_rate_select,
  output logic             slot_group_select,
  output logic             downstream_data_line_o,
  output logic             downstream_data_line_oe,
  input  wire logic        downstream_data_line_i,
  input  wire logic        upstream_data_line
);
  localparam int PH_W = (BIT_CYC > 1) ? $clog2(BIT_CYC) : 1;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(BIT_CYC - 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(BIT_CYC / 2);
  localparam logic [PH_W-1:0] PH_QTR  = PH_W'(BIT_CYC / 4);

  logic [PH_W-1:0] phase_reg;     // position inside one bus bit
  logic [7:0]      bit_reg;       // bit number inside the frame
  logic            fr_d;          // first cycle of a new frame
  logic            du_s1;         // upstream line, first stage
  logic            du_s2;         // upstream line, usable
  logic            dd_s1;         // downstream readback, first stage
  logic            dd_s2;         // downstream readback, usable
  logic [6:0]      up_sh;         // upstream shift register
  tcvf_ctl_s       up_ctl;        // device octet of the monitored pair
  logic [7:0]      up_mon;        // device monitor byte of that pair
  logic            up_mx_prev;    // device transmit flag, previous frame
  logic [1:0]      pair_reg;      // monitored channel pair
  tcvf_tx_e        tx_st;         // monitor transmitter state
  tcvf_rx_e        rx_st;         // monitor receiver state
  logic [7:0]      tx_byte_reg;   // byte on the downstream monitor slot
  logic            mx_reg;        // our transmit flag
  logic            mr_reg;        // our receive flag
  logic            mr_seen_reg;   // device receive flag was released
  logic [1:0]      tx_idle_cnt;   // idle frames while ending a message
  logic            coll_reg;      // collision seen in this frame
  logic [7:0]      look_reg;      // last monitor byte from the device
  logic            look_vld;      // look_reg holds a real byte
  logic [7:0]      fifo_data;
  logic            fifo_valid;
  logic            fifo_pop;
  logic            tx_start;
  logic            tx_ack;
  logic            last_ph;
  logic            frame_tick;
  logic            byte_done;
  logic [7:0]      up_byte;
  logic [2:0]      slot;
  logic [1:0]      byte_ix;
  logic [1:0]      pair;
  logic [2:0]      bpos;
  logic [2:0]      ch;
  logic            is_ctl;
  logic            is_mon;
  logic            mon_chk;
  logic [7:0]      dn_byte;
  logic            dn_bit;

  // queue of monitor bytes waiting for the handshake
  tcvf_fifo #(.W(8), .D(FIFO_D)) i_tcvf_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_data   (mon_tx_data),
    .in_valid  (mon_tx_valid),
    .in_ready  (mon_tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // frame position decode
  assign last_ph = (phase_reg == PH_LAST);
  assign frame_tick = last_ph && (bit_reg == `TCVF_LAST_BIT);
  assign byte_done = last_ph && (bit_reg[2:0] == 3'h7);
  assign slot = bit_reg[7:5];
  assign byte_ix = bit_reg[4:3];
  assign pair = slot[1:0];
  // RQ5: msb of each byte first
  assign bpos = 3'h7 - bit_reg[2:0];
  assign ch = {pair, byte_ix[1]};
  // RQ4: select pin picks which half carries control
  assign is_ctl = (slot[2] == slot_group_select);
  assign is_mon = is_ctl && (pair == pair_reg);
  assign up_byte = {up_sh, du_s2};

  // RQ22: one bit per BIT_CYC cycles whatever the clock rate
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= '0;
      bit_reg <= 8'h00;
    end else if (last_ph) begin
      phase_reg <= '0;
      // RQ1: 256 bits, eight slots of four bytes
      bit_reg <= bit_reg + 8'h01;
    end else begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // downstream byte for the current position
  always_comb begin
    dn_byte = `TCVF_IDLE_BYTE;
    if (is_ctl) begin
      // RQ2: two spare bytes, monitor byte, signaling octet
      if (byte_ix == `TCVF_MON_BYTE) begin
        // RQ10: queued command bytes go out here
        dn_byte = (is_mon && tx_st != TX_IDLE) ? tx_byte_reg : `TCVF_IDLE_BYTE;
      end else if (byte_ix == `TCVF_SIG_BYTE) begin
        // RQ8: sub-byte is channel select then five pin values
        dn_byte = {sig_down[pair], is_mon ? mr_reg : 1'b1, is_mon ? mx_reg : 1'b1};
      end
    end else begin
      // RQ3: channel A sample then channel B, high byte first
      dn_byte = byte_ix[0] ? voice_down[ch][7:0] : voice_down[ch][15:8];
    end
  end
  assign dn_bit = dn_byte[bpos];

  // pin outputs; open drain line is pulled low only for a zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_data_clock <= 1'b0;
      frame_sync <= 1'b0;
      downstream_data_line_o <= 1'b0;
      downstream_data_line_oe <= 1'b0;
      clock_rate_select <= 1'b0;
    end else begin
      if (DOUBLE) begin
        bus_data_clock <= (phase_reg < PH_QTR) ||
                          (phase_reg >= PH_HALF && phase_reg < PH_HALF + PH_QTR);
      end else begin
        bus_data_clock <= (phase_reg < PH_HALF);
      end
      // RQ23: sync marks bit 0 of every frame
      frame_sync <= (bit_reg == 8'h00);
      downstream_data_line_o <= 1'b0;
      downstream_data_line_oe <= !dn_bit;
      clock_rate_select <= DOUBLE;
    end
  end

  // slot group changes only at a frame boundary
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slot_group_select <= 1'b0;
      // reset leaves the counters at bit 0, so the first cycle is a frame start
      fr_d <= 1'b1;
      frame_done <= 1'b0;
    end else begin
      if (frame_tick) begin
        slot_group_select <= cfg_slot_group;
      end
      fr_d <= frame_tick;
      frame_done <= frame_tick;
    end
  end

  // two-stage synchronisers; nothing reads the first stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      du_s1 <= 1'b1;
      du_s2 <= 1'b1;
      dd_s1 <= 1'b1;
      dd_s2 <= 1'b1;
    end else begin
      du_s1 <= upstream_data_line;
      du_s2 <= du_s1;
      dd_s1 <= downstream_data_line_i;
      dd_s2 <= dd_s1;
    end
  end

  // upstream capture; the line is sampled late in each bit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      up_sh <= 7'h7F;
      up_ctl <= '1;
      up_mon <= `TCVF_IDLE_BYTE;
      sig_up <= '0;
      voice_up <= '0;
    end else if (last_ph) begin
      up_sh <= up_byte[6:0];
      if (byte_done && is_ctl && byte_ix == `TCVF_SIG_BYTE) begin
        // RQ6: b7-b2 are the input bits, then the two flags
        sig_up[pair] <= up_byte[7:2];
        if (is_mon) begin
          up_ctl <= up_byte;
        end
      end else if (byte_done && is_mon && byte_ix == `TCVF_MON_BYTE) begin
        up_mon <= up_byte;
      end else if (byte_done && !is_ctl) begin
        if (byte_ix[0]) begin
          voice_up[ch][7:0] <= up_byte;
        end else begin
          voice_up[ch][15:8] <= up_byte;
        end
      end
    end
  end

  // RQ17: a one we send that reads back as zero is a collision
  assign mon_chk = is_mon && (tx_st != TX_IDLE) && (byte_ix == `TCVF_MON_BYTE ||
                   (byte_ix == `TCVF_SIG_BYTE && bpos == `TCVF_FLAG_BIT));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      coll_reg <= 1'b0;
    end else if (last_ph && mon_chk && dn_bit && !dd_s2) begin
      coll_reg <= 1'b1;
    end else if (fr_d) begin
      coll_reg <= 1'b0;
    end
  end

  // RQ20: start only while the device is not sending
  assign tx_start = (tx_st == TX_IDLE) && fifo_valid && (rx_st == RX_IDLE);
  assign tx_ack = (tx_st == TX_SEND) && !up_ctl.mr && mr_seen_reg;
  // RQ19: next byte leaves the queue in the frame after the acknowledge
  assign fifo_pop = fr_d && (tx_start || (tx_ack && !coll_reg && fifo_valid));

  // the pair is chosen only while both directions are idle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pair_reg <= 2'h0;
    end else if (fr_d && tx_st == TX_IDLE && rx_st == RX_IDLE) begin
      pair_reg <= mon_pair;
    end
  end

  // RQ21: handshake decisions are taken once per frame only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_st <= TX_IDLE;
      mx_reg <= 1'b1;
      tx_byte_reg <= `TCVF_IDLE_BYTE;
      mr_seen_reg <= 1'b0;
      tx_idle_cnt <= 2'h0;
    end else if (fr_d) begin
      case (tx_st)
        TX_IDLE: begin
          if (tx_start) begin
            // RQ12: first byte goes out with the flag low
            tx_byte_reg <= fifo_data;
            mx_reg <= 1'b0;
            mr_seen_reg <= 1'b0;
            tx_st <= TX_SEND;
          end
        end
        TX_SEND: begin
          // RQ13: byte repeats while the receive flag is watched
          if (up_ctl.mr) begin
            mr_seen_reg <= 1'b1;
          end
          if (coll_reg) begin
            mx_reg <= 1'b1;
            tx_idle_cnt <= 2'h0;
            tx_st <= TX_EOM;
          end else if (tx_ack && fifo_valid) begin
            // new byte marked by one frame with the flag high
            tx_byte_reg <= fifo_data;
            mx_reg <= 1'b1;
            mr_seen_reg <= 1'b0;
            tx_st <= TX_NEW;
          end else if (tx_ack && !mon_tx_hold) begin
            // RQ25: message done, flag back high
            mx_reg <= 1'b1;
            tx_idle_cnt <= 2'h0;
            tx_st <= TX_EOM;
          end
          // RQ15: an empty queue under hold waits with both flags low
        end
        TX_NEW: begin
          if (up_ctl.mr) begin
            mr_seen_reg <= 1'b1;
          end
          if (coll_reg) begin
            tx_idle_cnt <= 2'h0;
            tx_st <= TX_EOM;
          end else begin
            mx_reg <= 1'b0;
            tx_st <= TX_SEND;
          end
        end
        TX_EOM: begin
          // RQ11: two frames with both flags high end the message
          if (!up_ctl.mr) begin
            tx_idle_cnt <= 2'h0;
          end else if (tx_idle_cnt == `TCVF_IDLE_FRAMES - 2'h1) begin
            tx_st <= TX_IDLE;
          end else begin
            tx_idle_cnt <= tx_idle_cnt + 2'h1;
          end
        end
        default: begin
          mx_reg <= 1'b1;
          tx_st <= TX_IDLE;
        end
      endcase
    end
  end

  // receiver for monitor bytes sent by the device
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_st <= RX_IDLE;
      mr_reg <= 1'b1;
      look_reg <= `TCVF_IDLE_BYTE;
      look_vld <= 1'b0;
      up_mx_prev <= 1'b1;
    end else if (fr_d) begin
      up_mx_prev <= up_ctl.mx;
      case (rx_st)
        RX_IDLE: begin
          if (!up_ctl.mx && tx_st == TX_IDLE) begin
            look_reg <= up_mon;
            look_vld <= 1'b1;
            rx_st <= RX_LOOK;
          end
        end
        RX_LOOK: begin
          if (up_ctl.mx) begin
            look_vld <= 1'b0;
            // RQ11: flag high twice running is the end of message
            if (up_mx_prev) begin
              rx_st <= RX_IDLE;
            end
          end else if (look_vld && up_mon == look_reg) begin
            // RQ16: two equal frames before acceptance
            // RQ14: acknowledge while the byte is still there
            mr_reg <= 1'b0;
            rx_st <= RX_ACK;
          end else begin
            look_reg <= up_mon;
            look_vld <= 1'b1;
          end
        end
        RX_ACK: begin
          // RQ25: release on the inactive phase or a changed byte
          if (up_ctl.mx || up_mon != look_reg) begin
            mr_reg <= 1'b1;
            look_reg <= up_mon;
            look_vld <= !up_ctl.mx;
            rx_st <= RX_LOOK;
          end
        end
        default: begin
          mr_reg <= 1'b1;
          rx_st <= RX_IDLE;
        end
      endcase
    end
  end

  // user-side pulses and status, all from flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mon_rx_data <= 8'h00;
      mon_rx_valid <= 1'b0;
      mon_eom <= 1'b0;
      mon_abort <= 1'b0;
      mon_busy <= 1'b0;
    end else begin
      mon_rx_valid <= fr_d && rx_st == RX_LOOK && !up_ctl.mx && look_vld &&
                      up_mon == look_reg;
      if (fr_d && rx_st == RX_LOOK && look_vld && up_mon == look_reg) begin
        mon_rx_data <= up_mon;
      end
      mon_eom <= fr_d && ((rx_st == RX_LOOK && up_ctl.mx && up_mx_prev) ||
                 (tx_st == TX_EOM && up_ctl.mr &&
                  tx_idle_cnt == `TCVF_IDLE_FRAMES - 2'h1));
      // abort tells the user the device will drop its command stack
      mon_abort <= fr_d && coll_reg && (tx_st == TX_SEND || tx_st == TX_NEW);
      mon_busy <= (tx_st != TX_IDLE) || (rx_st != RX_IDLE);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_frame_wrap;
    frame_tick |=> (bit_reg == 8'h00) && (phase_reg == '0) && fr_d;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) // RQ1
    else $error("frame does not wrap after bit 255");

  property p_sync_pos;
    $rose(frame_sync) |-> $past(bit_reg) == 8'h00 && $past(fr_d);
  endproperty
  a_sync_pos: assert property (p_sync_pos) // RQ23
    else $error("frame sync not at frame start");

  property p_byte_steady;
    !fr_d |=> $stable(tx_byte_reg) && $stable(mx_reg);
  endproperty
  a_byte_steady: assert property (p_byte_steady) // RQ13
    else $error("monitor byte changed inside a frame");

  property p_send_low;
    tx_st == TX_SEND |-> !mx_reg;
  endproperty
  a_send_low: assert property (p_send_low) // RQ12
    else $error("transmit flag high while sending");

  property p_accept_ack;
    mon_rx_valid |-> !mr_reg && rx_st == RX_ACK && mon_rx_data == look_reg;
  endproperty
  a_accept_ack: assert property (p_accept_ack) // RQ14
    else $error("byte accepted without acknowledge");

  property p_no_duplex;
    (tx_st == TX_IDLE) ##1 (tx_st != TX_IDLE) |-> $past(rx_st == RX_IDLE);
  endproperty
  a_no_duplex: assert property (p_no_duplex) // RQ20
    else $error("transmit started while device sends");

  property p_coll_abort;
    fr_d && coll_reg && tx_st == TX_SEND |=> tx_st == TX_EOM && mx_reg ##0 mon_abort;
  endproperty
  a_coll_abort: assert property (p_coll_abort) // RQ17
    else $error("collision did not abort");

  property p_first_frame;
    tx_st == TX_IDLE ##1 tx_st == TX_SEND |-> !mr_seen_reg;
  endproperty
  a_first_frame: assert property (p_first_frame) // RQ16
    else $error("acknowledge accepted before a repeat");

  property p_bit_len;
    last_ph |=> phase_reg == '0 ##1 phase_reg == PH_W'(1);
  endproperty
  a_bit_len: assert property (p_bit_len) // RQ22
    else $error("bit period broken");

  c_tx_start: cover property (tx_st == TX_IDLE ##1 tx_st == TX_SEND);
  c_tx_next: cover property (tx_st == TX_NEW ##1 tx_st == TX_SEND);
  c_rx_accept: cover property (mon_rx_valid);
  c_eom: cover property (mon_eom);
  c_abort: cover property (mon_abort);
endmodule
